// [src/sos_standby_ctl.sv]
// standby mode controller with settle wait, registers and interrupt
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_standby_ctl import sos_pkg::*; #(
	parameter bit RING_STOPPABLE = 1'b1   // build option: software may stop internal_ring_oscillator
) (
	input  wire logic        mclk,              // 100 MHz clock
	input  wire logic        rst_n,             // sync reset, active low
	input  wire logic [7:0]  regAddr,           // register address
	input  wire logic [31:0] regWdata,          // write data
	input  wire logic        regWr,             // write strobe
	input  wire logic        regRd,             // read strobe
	output logic      [31:0] regRdata,          // read data, cycle after strobe
	input  wire logic        irqPending,        // some request set and unmasked
	input  wire logic        crystalClockInput, // sampled crystal clock
	input  wire logic        ringTick,          // ring oscillator period pulse
	output logic             cpuRun,            // CPU may execute
	output logic             stopMode,          // in stop
	output logic             haltMode,          // in halt or degraded stop
	output logic             crystalEnable,     // crystal oscillator on
	output logic             ringOscEnable,     // ring oscillator on
	output logic             irq                // level interrupt
);
	sos_mode_e             state_q, state_d;
	logic                  cpuRing_q, cpuRing_d;
	logic                  ringEn_q, ringEn_d;
	logic                  degr_q, degr_d;
	logic [`SOS_SEL_W-1:0] sel_q, sel_d;
	logic [`SOS_EV_W-1:0]  ist_q, ist_d, ien_q, ien_d, ev;
	logic                  irq_q, irq_d;
	logic                  cpuRun_q, cpuRun_d;
	logic                  stop_q, stop_d;
	logic                  halt_q, halt_d;
	logic                  xtalEn_q, xtalEn_d;
	logic [31:0]           rdata_q, rdata_d;
	logic                  wrCtl, stopReq, haltReq;
	logic                  setStart, setClr, ringStart, ringDone;

	sos_settle_if settle ();

	sos_settle_counter u_counter (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.xtalIn (crystalClockInput),
		.lnk    (settle.cnt)
	);

	sos_ring_wait u_ring (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.start    (ringStart),
		.ringTick (ringTick),
		.done     (ringDone)
	);

	assign settle.start = setStart;
	assign settle.clr = setClr;
	assign settle.sel = sel_q;

	// mode sequencing and control bits
	always_comb begin
		state_d = state_q;
		cpuRing_d = cpuRing_q;
		ringEn_d = ringEn_q;
		degr_d = degr_q;
		sel_d = sel_q;
		ev = '0;
		setStart = 1'b0;
		setClr = 1'b0;
		ringStart = 1'b0;
		stopReq = 1'b0;
		haltReq = 1'b0;
		// control writes only land while running: the CPU is parked otherwise
		wrCtl = regWr && (regAddr == `SOS_A_CTRL) && (state_q == SOS_RUN);
		if (wrCtl) begin
			cpuRing_d = regWdata[`SOS_B_CPURING];
			// the internal_ring_oscillator cannot be stopped while it clocks the CPU
			if (RING_STOPPABLE && !regWdata[`SOS_B_CPURING]) ringEn_d = !regWdata[`SOS_B_RINGSTOP];
			stopReq = regWdata[`SOS_B_STOPREQ];
			haltReq = regWdata[`SOS_B_HALTREQ];
		end
		if (regWr && (regAddr == `SOS_A_SEL)) sel_d = regWdata[`SOS_SEL_W-1:0];
		case (state_q)
			SOS_BOOT: begin
				// reset release: settle wait too, counted from first oscillation
				setStart = 1'b1;
				state_d = SOS_SETTLE;
			end
			SOS_RUN: begin
				if (stopReq) begin
					setClr = 1'b1;
					if (irqPending) begin
						degr_d = 1'b1;
						ev[`SOS_EV_DEGRADE] = 1'b1;
						setStart = 1'b1;
						ringStart = cpuRing_d;
						state_d = SOS_SETTLE;
					end else begin
						ev[`SOS_EV_STOPIN] = 1'b1;
						state_d = SOS_STOP;
					end
				end else if (haltReq && !irqPending) begin
					state_d = SOS_HALT;
				end
			end
			SOS_HALT: if (irqPending) state_d = SOS_RUN;
			SOS_STOP: begin
				if (irqPending) begin
					setStart = 1'b1;
					ringStart = cpuRing_q;
					state_d = SOS_SETTLE;
				end
			end
			SOS_SETTLE: begin
				if (cpuRing_q ? ringDone : settle.done) begin
					state_d = SOS_RUN;
					degr_d = 1'b0;
					ev[`SOS_EV_READY] = 1'b1;
				end
			end
			default: state_d = SOS_BOOT;
		endcase
	end

	// interrupt bits, outputs and read data
	always_comb begin
		ien_d = ien_q;
		if (regWr && (regAddr == `SOS_A_IEN)) ien_d = regWdata[`SOS_EV_W-1:0];
		// a new event in the clearing cycle survives
		ist_d = ist_q | ev;
		if (regWr && (regAddr == `SOS_A_ICLR)) ist_d = (ist_q & ~regWdata[`SOS_EV_W-1:0]) | ev;
		irq_d = |(ist_d & ien_d);
		cpuRun_d = (state_d == SOS_RUN);
		stop_d = (state_d == SOS_STOP);
		halt_d = (state_d == SOS_HALT) || (state_d == SOS_SETTLE && degr_d);
		// crystal is off only in full stop
		xtalEn_d = (state_d != SOS_STOP);
		rdata_d = '0;
		if (regRd) begin
			case (regAddr)
				`SOS_A_CTRL: begin
					rdata_d[`SOS_B_RINGSTOP] = !ringEn_q;
					rdata_d[`SOS_B_CPURING] = cpuRing_q;
				end
				`SOS_A_SEL:  rdata_d[`SOS_SEL_W-1:0] = sel_q;
				`SOS_A_STAT: rdata_d[`SOS_ST_W-1:0] = settle.status;
				`SOS_A_MODE: begin
					rdata_d[2:0] = state_q;
					rdata_d[`SOS_B_DEGR] = degr_q;
				end
				`SOS_A_IST:  rdata_d[`SOS_EV_W-1:0] = ist_q;
				`SOS_A_IEN:  rdata_d[`SOS_EV_W-1:0] = ien_q;
				default:     rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= SOS_BOOT;
			cpuRing_q <= 1'b0;
			ringEn_q <= 1'b1;
			degr_q <= 1'b0;
			sel_q <= `SOS_SEL_RST;
			ist_q <= '0;
			ien_q <= '0;
			irq_q <= 1'b0;
			cpuRun_q <= 1'b0;
			stop_q <= 1'b0;
			halt_q <= 1'b0;
			xtalEn_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			state_q <= state_d;
			cpuRing_q <= cpuRing_d;
			ringEn_q <= ringEn_d;
			degr_q <= degr_d;
			sel_q <= sel_d;
			ist_q <= ist_d;
			ien_q <= ien_d;
			irq_q <= irq_d;
			cpuRun_q <= cpuRun_d;
			stop_q <= stop_d;
			halt_q <= halt_d;
			xtalEn_q <= xtalEn_d;
			rdata_q <= rdata_d;
		end
	end

	assign regRdata = rdata_q;
	assign cpuRun = cpuRun_q;
	assign stopMode = stop_q;
	assign haltMode = halt_q;
	assign crystalEnable = xtalEn_q;
	assign ringOscEnable = ringEn_q;
	assign irq = irq_q;

	property p_ring_locked;
		@(posedge mclk) disable iff (!rst_n)
		!ringEn_q |-> RING_STOPPABLE;
	endproperty
	a_ring_locked: assert property (p_ring_locked) else $error("internal_ring_oscillator stopped without option");
	property p_stop_keeps_ring;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_STOP) |=> (ringEn_q == $past(ringEn_q));
	endproperty
	a_stop_keeps_ring: assert property (p_stop_keeps_ring) else $error("internal_ring_oscillator changed in stop");
	property p_degrade;
		@(posedge mclk) disable iff (!rst_n)
		(wrCtl && regWdata[`SOS_B_STOPREQ] && irqPending) |=> (state_q == SOS_SETTLE && degr_q) ##1 halt_q;
	endproperty
	a_degrade: assert property (p_degrade) else $error("pending request did not degrade stop");
	property p_clear_on_entry;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_STOP && $past(state_q) != SOS_STOP) |-> (settle.status == '0 && stop_q);
	endproperty
	a_clear_on_entry: assert property (p_clear_on_entry) else $error("status not cleared at stop entry");
	property p_ring_resume;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_SETTLE && cpuRing_q && !ringDone) |=> (state_q != SOS_RUN);
	endproperty
	a_ring_resume: assert property (p_ring_resume) else $error("CPU resumed before ring hold");
	// ring option checks, then sequencing checks around stop, halt and settle
	property p_ring_ignored;
		@(posedge mclk) disable iff (!rst_n)
		(wrCtl && !RING_STOPPABLE) |=> (ringEn_q == $past(ringEn_q));
	endproperty
	a_ring_ignored: assert property (p_ring_ignored) else $error("ring stop honoured without option");
	property p_ring_honoured;
		@(posedge mclk) disable iff (!rst_n)
		(wrCtl && RING_STOPPABLE && !regWdata[`SOS_B_CPURING])
			|=> (ringEn_q == !$past(regWdata[`SOS_B_RINGSTOP]));
	endproperty
	a_ring_honoured: assert property (p_ring_honoured) else $error("ring stop write not applied");
	property p_stop_entry;
		@(posedge mclk) disable iff (!rst_n)
		(wrCtl && regWdata[`SOS_B_STOPREQ] && !irqPending) |=> (state_q == SOS_STOP && stop_q && !xtalEn_q);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop request without pending not taken");
	property p_stop_hold;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_STOP && !irqPending) |=> (state_q == SOS_STOP && stop_q && !xtalEn_q);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without request");
	property p_stop_exit;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_STOP && irqPending) |=> (state_q == SOS_SETTLE && !stop_q && xtalEn_q);
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop release did not start settle");
	property p_stop_zero;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_STOP) |-> (settle.status == '0);
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("status nonzero during stop");
	property p_settle_entry;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_SETTLE && $past(state_q) != SOS_SETTLE) |-> (settle.status == '0);
	endproperty
	a_settle_entry: assert property (p_settle_entry) else $error("settle began with stale status");
	property p_boot;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_BOOT) |=> (state_q == SOS_SETTLE);
	endproperty
	a_boot: assert property (p_boot) else $error("reset release skipped settle wait");
	property p_xtal_wait;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_SETTLE && !cpuRing_q && !settle.done) |=> (state_q != SOS_RUN);
	endproperty
	a_xtal_wait: assert property (p_xtal_wait) else $error("CPU resumed before crystal settle");
	property p_xtal_done;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_SETTLE && !cpuRing_q && settle.done) |=> (state_q == SOS_RUN && cpuRun_q);
	endproperty
	a_xtal_done: assert property (p_xtal_done) else $error("CPU not resumed after crystal settle");
	property p_done_sel;
		@(posedge mclk) disable iff (!rst_n)
		(settle.done && sel_q <= `SOS_SEL_MAX) |-> settle.status[sel_q];
	endproperty
	a_done_sel: assert property (p_done_sel) else $error("settle done before selected time");
	property p_ring_done;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_SETTLE && cpuRing_q && ringDone) |=> (state_q == SOS_RUN && cpuRun_q);
	endproperty
	a_ring_done: assert property (p_ring_done) else $error("CPU not resumed after ring hold");
	property p_halt_wait;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_HALT && !irqPending) |=> (state_q == SOS_HALT && halt_q && !cpuRun_q);
	endproperty
	a_halt_wait: assert property (p_halt_wait) else $error("halt left without request");
	property p_halt_exit;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == SOS_HALT && irqPending) |=> (state_q == SOS_RUN && cpuRun_q);
	endproperty
	a_halt_exit: assert property (p_halt_exit) else $error("halt not cleared by request");
	property p_halt_refused;
		@(posedge mclk) disable iff (!rst_n)
		(wrCtl && regWdata[`SOS_B_HALTREQ] && !regWdata[`SOS_B_STOPREQ] && irqPending)
			|=> (state_q == SOS_RUN);
	endproperty
	a_halt_refused: assert property (p_halt_refused) else $error("halt taken with pending request");
	property p_degr_only_settle;
		@(posedge mclk) disable iff (!rst_n)
		degr_q |-> (state_q == SOS_SETTLE && halt_q);
	endproperty
	a_degr_only_settle: assert property (p_degr_only_settle) else $error("degraded flag outside settle");
endmodule

// [src/sos_defs.svh]
// constants for the standby and oscillator settle controller
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH
`define SOS_A_CTRL      8'h00
`define SOS_A_SEL       8'h04
`define SOS_A_STAT      8'h08
`define SOS_A_MODE      8'h0c
`define SOS_A_IST       8'h10
`define SOS_A_ICLR      8'h14
`define SOS_A_IEN       8'h18
`define SOS_B_RINGSTOP  0
`define SOS_B_CPURING   1
`define SOS_B_STOPREQ   2
`define SOS_B_HALTREQ   3
`define SOS_B_DEGR      4
`define SOS_EV_STOPIN   0
`define SOS_EV_READY    1
`define SOS_EV_DEGRADE  2
`define SOS_EV_W        3
`define SOS_SEL_W       3
`define SOS_SEL_RST     3'h4
`define SOS_SEL_MAX     3'h4
`define SOS_ST_W        5
`define SOS_CNT_W       16
`define SOS_THR_BASE    4
`define SOS_THR_STEP    2
`define SOS_RING_WAIT   5'h11
`define SOS_RING_W      5
`endif

// [src/sos_pkg.sv]
// types shared by the standby controller modules
package sos_pkg;
	typedef enum logic [2:0] {SOS_BOOT, SOS_RUN, SOS_HALT, SOS_STOP, SOS_SETTLE} sos_mode_e;
	typedef enum logic [1:0] {SOS_IDLE, SOS_ARM, SOS_COUNT} sos_cnt_e;
endpackage

// [src/sos_settle_if.sv]
// link between the mode controller and the settle counter
`timescale 1ns/1ps
`include "sos_defs.svh"
interface sos_settle_if;
	logic                  start;
	logic                  clr;
	logic [`SOS_SEL_W-1:0] sel;
	logic                  done;
	logic [`SOS_ST_W-1:0]  status;
	modport ctl (output start, clr, sel, input done, status);
	modport cnt (input start, clr, sel, output done, status);
endinterface

// [src/sos_settle_counter.sv]
// crystal settle counter and its threshold status bits
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_settle_counter import sos_pkg::*; (
	input  wire logic mclk,        // system clock
	input  wire logic rst_n,       // sync reset, active low
	input  wire logic xtalIn,      // sampled crystal clock
	sos_settle_if.cnt lnk          // counter side
);
	sos_cnt_e              st_q, st_d;
	logic [`SOS_CNT_W-1:0] cnt_q, cnt_d;
	logic [`SOS_ST_W-1:0]  status_q, status_d, reached;
	logic                  xtalPrev_q, done_q, done_d;
	logic                  xtalRise;
	logic [`SOS_SEL_W-1:0] selClip;

	assign xtalRise = xtalIn && !xtalPrev_q;
	assign selClip = (lnk.sel > `SOS_SEL_MAX) ? `SOS_SEL_MAX : lnk.sel;
	genvar i;
	generate
		for (i = 0; i < `SOS_ST_W; i++) begin : g_thr
			assign reached[i] = cnt_q[`SOS_THR_BASE + `SOS_THR_STEP * i] && (i <= selClip);
		end
	endgenerate

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		status_d = status_q;
		done_d = 1'b0;
		case (st_q)
			SOS_ARM: if (xtalRise) st_d = SOS_COUNT;
			SOS_COUNT: begin
				if (xtalRise) cnt_d = cnt_q + 1'b1;
				status_d = status_q | reached;
				if (status_q[selClip]) begin
					st_d = SOS_IDLE;
					done_d = 1'b1;
				end
			end
			default: st_d = SOS_IDLE;
		endcase
		if (lnk.clr || lnk.start) begin
			status_d = '0;
			cnt_d = '0;
			st_d = lnk.start ? SOS_ARM : SOS_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= SOS_IDLE;
			cnt_q <= '0;
			status_q <= '0;
			xtalPrev_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			status_q <= status_d;
			xtalPrev_q <= xtalIn;
			done_q <= done_d;
		end
	end
	assign lnk.status = status_q;
	assign lnk.done = done_q;

	property p_thermo;
		@(posedge mclk) disable iff (!rst_n)
		(((status_q + 1'b1) & status_q) == '0) && ((status_q & $past(status_q)) == $past(status_q) || $past(lnk.clr || lnk.start));
	endproperty
	a_thermo: assert property (p_thermo) else $error("status bits not set in order");
	property p_sel_bound;
		@(posedge mclk) disable iff (!rst_n)
		(st_q == SOS_COUNT) |-> ((status_q >> (selClip + 1)) == '0);
	endproperty
	a_sel_bound: assert property (p_sel_bound) else $error("status beyond selected time");
	property p_arm;
		@(posedge mclk) disable iff (!rst_n)
		(st_q == SOS_ARM && !xtalRise && !lnk.start && !lnk.clr) |=> (cnt_q == '0 && st_q == SOS_ARM);
	endproperty
	a_arm: assert property (p_arm) else $error("counted before oscillation");
endmodule

// [src/sos_ring_wait.sv]
// hold count of ring oscillator periods after stop release
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_ring_wait (
	input  wire logic mclk,      // system clock
	input  wire logic rst_n,     // sync reset, active low
	input  wire logic start,     // begin a hold
	input  wire logic ringTick,  // one pulse per ring period
	output logic      done       // hold over, one cycle
);
	logic [`SOS_RING_W-1:0] cnt_q, cnt_d;
	logic                   busy_q, busy_d, done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (start) begin
			cnt_d = '0;
			busy_d = 1'b1;
		end else if (busy_q && ringTick) begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_q == `SOS_RING_WAIT - 1'b1) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end
	assign done = done_q;

	property p_ring_hold;
		@(posedge mclk) disable iff (!rst_n)
		done_q |-> (cnt_q == `SOS_RING_WAIT && $past(ringTick) && !busy_q);
	endproperty
	a_ring_hold: assert property (p_ring_hold) else $error("ring hold not 17 periods");
endmodule

// [tb/sos_tb.sv]
// self-checking bench for the standby and settle controller
`timescale 1ns/1ps
`include "sos_defs.svh"
module tb;
	logic        mclk;
	logic        rst_n;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic [31:0] rdVal;
	logic        irqPending;
	logic        crystalClockInput;
	logic        ringTick;
	logic        xtalRun;
	logic        cpuRun;
	logic        stopMode;
	logic        haltMode;
	logic        crystalEnable;
	logic        ringOscEnable;
	logic        irq;
	logic        ringEnFixed;
	int          mismatches;
	int          checks;
	int          cyc;

	sos_standby_ctl #(.RING_STOPPABLE(1'b1)) DUT (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqPending(irqPending),
		.crystalClockInput(crystalClockInput), .ringTick(ringTick), .cpuRun(cpuRun), .stopMode(stopMode),
		.haltMode(haltMode), .crystalEnable(crystalEnable), .ringOscEnable(ringOscEnable), .irq(irq));

	// same stimulus, build option off: ring stop must be ignored
	sos_standby_ctl #(.RING_STOPPABLE(1'b0)) DUT2 (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(), .irqPending(irqPending),
		.crystalClockInput(crystalClockInput), .ringTick(ringTick), .cpuRun(), .stopMode(),
		.haltMode(), .crystalEnable(), .ringOscEnable(ringEnFixed), .irq());

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic print_verdict();
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// crystal toggles each cycle while running, so one period is two cycles
	always @(posedge mclk) begin
		cyc++;
		crystalClockInput <= xtalRun ? ~crystalClockInput : 1'b0;
		if (cyc > 40000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 rdVal = regRdata;
	endtask

	task automatic waitRun(input int lim);
		int n;
		n = 0;
		while (cpuRun !== 1'b1 && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(cpuRun, 1'b1);
	endtask

	task automatic pulseIrq();
		@(posedge mclk);
		irqPending <= 1'b1;
		@(posedge mclk);
		irqPending <= 1'b0;
	endtask

	task automatic settle(input int lim);
		repeat (lim) @(posedge mclk);
	endtask

	initial begin
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		irqPending = 1'b0;
		ringTick = 1'b0;
		xtalRun = 1'b0;
		crystalClockInput = 1'b0;
		mismatches = 0;
		checks = 0;
		cyc = 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk({cpuRun, stopMode, haltMode, crystalEnable, ringOscEnable, irq}, 6'b000110);
		// no crystal yet: nothing may be counted
		settle(60);
		rd(`SOS_A_STAT);
		chk(rdVal, 32'h0);
		chk(cpuRun, 1'b0);
		xtalRun <= 1'b1;
		waitRun(9000);
		rd(`SOS_A_STAT);
		chk(rdVal, 32'h1f);
		rd(`SOS_A_IST);
		chk(rdVal, 32'h1 << `SOS_EV_READY);
		chk(irq, 1'b0);
		wr(`SOS_A_IEN, 32'h7);
		settle(2);
		chk(irq, 1'b1);
		wr(`SOS_A_ICLR, 32'h7);
		settle(2);
		chk(irq, 1'b0);
		rd(`SOS_A_IST);
		chk(rdVal, 32'h0);
		rd(8'h40);
		chk(rdVal, 32'h0);
		// stop on crystal with a short select
		wr(`SOS_A_SEL, 32'h1);
		wr(`SOS_A_CTRL, 32'h4);
		xtalRun <= 1'b0;
		settle(3);
		chk({stopMode, crystalEnable, cpuRun}, 3'b100);
		chk(ringOscEnable, 1'b1);
		rd(`SOS_A_STAT);
		chk(rdVal, 32'h0);
		settle(20);
		pulseIrq();
		xtalRun <= 1'b1;
		rdVal = 32'h0;
		for (int i = 0; i < 100 && rdVal == 32'h0; i++) begin
			rd(`SOS_A_STAT);
		end
		chk(rdVal, 32'h1);
		waitRun(600);
		rd(`SOS_A_STAT);
		chk(rdVal, 32'h3);
		rd(`SOS_A_IST);
		chk(rdVal, 32'h3);
		chk(irq, 1'b1);
		wr(`SOS_A_ICLR, 32'h7);
		// pending unmasked request turns stop into halt
		irqPending <= 1'b1;
		wr(`SOS_A_CTRL, 32'h4);
		irqPending <= 1'b0;
		settle(2);
		chk({haltMode, stopMode}, 2'b10);
		rd(`SOS_A_MODE);
		chk(rdVal, 32'h14);
		waitRun(600);
		rd(`SOS_A_IST);
		chk(rdVal[`SOS_EV_DEGRADE], 1'b1);
		wr(`SOS_A_ICLR, 32'h7);
		wr(`SOS_A_CTRL, 32'h1);
		settle(2);
		chk({ringOscEnable, ringEnFixed}, 2'b01);
		rd(`SOS_A_CTRL);
		chk(rdVal, 32'h1);
		wr(`SOS_A_CTRL, 32'h0);
		settle(2);
		chk(ringOscEnable, 1'b1);
		// halt, then a halt refused because a request is pending
		wr(`SOS_A_CTRL, 32'h8);
		settle(2);
		chk({haltMode, stopMode, cpuRun}, 3'b100);
		pulseIrq();
		waitRun(4);
		irqPending <= 1'b1;
		wr(`SOS_A_CTRL, 32'h8);
		irqPending <= 1'b0;
		settle(2);
		chk({haltMode, cpuRun}, 2'b01);
		// ring-clocked stop; crystal held still so only ring ticks can end the hold
		xtalRun <= 1'b0;
		wr(`SOS_A_CTRL, 32'h2);
		wr(`SOS_A_CTRL, 32'h6);
		settle(3);
		chk({stopMode, ringOscEnable}, 2'b11);
		pulseIrq();
		settle(4);
		for (int i = 1; i <= 17; i++) begin
			settle(3);
			ringTick <= 1'b1;
			@(posedge mclk);
			ringTick <= 1'b0;
			if (i == 16) begin
				settle(4);
				chk(cpuRun, 1'b0);
			end
		end
		waitRun(8);
		// ring release leaves the counter armed; let the crystal finish it
		xtalRun <= 1'b1;
		rdVal = 32'h0;
		for (int i = 0; i < 200 && rdVal[1] == 1'b0; i++) begin
			rd(`SOS_A_STAT);
		end
		chk(rdVal, 32'h3);
		// mid-run reset must clear status and reload select with 4
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk({cpuRun, stopMode, haltMode, crystalEnable, ringOscEnable, irq}, 6'b000110);
		rd(`SOS_A_STAT);
		chk(rdVal, 32'h0);
		rd(`SOS_A_SEL);
		chk(rdVal, 32'h4);
		waitRun(9000);
		print_verdict();
	end
endmodule
